// File: logic/ext_move_router.sv
// Picks the target of an external-move access
`timescale 1ns/1ps
module ext_move_router (
  // Access in
  input wire logic [15:0] ext_addr,
  input wire logic flash_access,
  // Target out
  output timing_pkg::target_t target
);
  // Flash access wins over the address split so the whole code space
  // stays reachable while it is selected
  always_comb begin
    if (flash_access)
      target = timing_pkg::TGT_FLASH;
    else if (ext_addr < timing_pkg::EXT_RAM_SIZE)
      target = timing_pkg::TGT_EXT_RAM;
    else
      target = timing_pkg::TGT_OFF_CHIP;
  end
endmodule

// File: logic/instr_timing.sv
// Instruction timing sequencer with external-move routing
`timescale 1ns/1ps
module instr_timing (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Issue
  input wire logic issue_valid,
  input wire timing_pkg::instr_t issue,
  output logic ready,
  // Completion
  output logic done,
  output logic [1:0] bytes_out,
  output logic [3:0] cycles_out,
  output logic [7:0] nibble_mask,
  // External-move routing
  output logic route_valid,
  output timing_pkg::target_t target,
  output logic [15:0] route_addr,
  output logic route_wide
);
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } state_t;

  timing_pkg::timing_t lut;
  timing_pkg::target_t lut_target;
  state_t state;
  state_t next_state;
  logic [3:0] remain;
  logic [3:0] next_remain;
  logic next_ready;
  logic next_done;
  logic [1:0] next_bytes;
  logic [3:0] next_cycles;
  logic [7:0] next_mask;
  logic next_route_valid;
  timing_pkg::target_t next_target;
  logic [15:0] next_route_addr;
  logic next_route_wide;
  logic accept;
  logic [15:0] eff_addr;

  timing_lookup u_lookup (
    .instr(issue),
    .timing(lut)
  );

  // A narrow pointer only supplies the low address byte; routing follows
  // that effective address so stale upper bits never reach off-chip space
  assign eff_addr = issue.ptr_wide ? issue.ext_addr
                                   : {8'h00, issue.ext_addr[7:0]};

  ext_move_router u_router (
    .ext_addr(eff_addr),
    .flash_access(issue.flash_access),
    .target(lut_target)
  );

  assign accept = issue_valid && ready;

  // Sequencer: one-cycle instructions complete without leaving idle, so
  // single-cycle code streams at full rate
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_done = 1'b0;
    next_bytes = bytes_out;
    next_cycles = cycles_out;
    if (state == ST_IDLE) begin
      if (accept) begin
        next_bytes = lut.bytes;
        next_cycles = lut.cycles;
        next_remain = lut.cycles - timing_pkg::CYC_1;
        if (lut.cycles == timing_pkg::CYC_1)
          next_done = 1'b1;
        else
          next_state = ST_EXEC;
      end
    end else begin
      if (remain == timing_pkg::CYC_1) begin
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      next_remain = remain - timing_pkg::CYC_1;
    end
    next_ready = (next_state == ST_IDLE);
  end

  // Exchange mask and external-move routing are captured at issue
  always_comb begin
    next_mask = nibble_mask;
    next_route_valid = 1'b0;
    next_target = target;
    next_route_addr = route_addr;
    next_route_wide = route_wide;
    if (accept) begin
      case (issue.op)
        timing_pkg::OP_LOW_NIBBLE_XCH: next_mask = timing_pkg::MASK_LOW;
        timing_pkg::OP_XCH: next_mask = timing_pkg::MASK_ALL;
        default: next_mask = timing_pkg::MASK_NONE;
      endcase
      if (issue.op == timing_pkg::OP_EXT_MOVE) begin
        next_route_valid = 1'b1;
        next_target = lut_target;
        next_route_addr = eff_addr;
        next_route_wide = issue.ptr_wide;
      end else begin
        next_target = timing_pkg::TGT_NONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      remain <= 4'h0;
      ready <= 1'b1;
      done <= 1'b0;
      bytes_out <= 2'h0;
      cycles_out <= 4'h0;
      nibble_mask <= 8'h00;
      route_valid <= 1'b0;
      target <= timing_pkg::TGT_NONE;
      route_addr <= 16'h0000;
      route_wide <= 1'b0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      ready <= next_ready;
      done <= next_done;
      bytes_out <= next_bytes;
      cycles_out <= next_cycles;
      nibble_mask <= next_mask;
      route_valid <= next_route_valid;
      target <= next_target;
      route_addr <= next_route_addr;
      route_wide <= next_route_wide;
    end
  end

  // Cycles since the last issue, read only by the checks below
  logic [3:0] elapsed;
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      elapsed <= 4'h0;
    else if (accept)
      elapsed <= 4'h1;
    else if (elapsed != 4'hf)
      elapsed <= elapsed + 4'h1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  done_count_a: assert property (
    done |-> elapsed == cycles_out)
    else $error("done does not match latched cycle count");
  one_cycle_a: assert property (
    accept && issue.op == timing_pkg::OP_CARRY |=> done && ready)
    else $error("carry op did not finish in one cycle");
  mul_four_a: assert property (
    accept && issue.op == timing_pkg::OP_MUL |=> !done [*3] ##1 done)
    else $error("multiply not four cycles");
  div_eight_a: assert property (
    accept && issue.op == timing_pkg::OP_DIV |-> ##8 done && cycles_out == 4'h8)
    else $error("divide not eight cycles");
  logic_three_a: assert property (
    accept && issue.op == timing_pkg::OP_LOGIC &&
    issue.dst == timing_pkg::MODE_DIRECT && issue.src == timing_pkg::MODE_IMM
    |=> bytes_out == 2'h3 && cycles_out == 4'h3)
    else $error("logic immediate to direct not 3 bytes 3 cycles");
  busy_hold_a: assert property (
    accept && issue.op == timing_pkg::OP_EXT_MOVE |=> !ready ##1 !ready ##1 ready)
    else $error("external move ready timing wrong");
  branch_taken_a: assert property (
    accept && issue.op == timing_pkg::OP_COND_BRANCH
    |=> cycles_out == {2'h0, bytes_out} + {3'h0, $past(issue.taken)})
    else $error("branch cycles do not follow taken flag");
  route_external_data_ram_a: assert property (
    accept && issue.op == timing_pkg::OP_EXT_MOVE && !issue.flash_access &&
    issue.ptr_wide && issue.ext_addr < timing_pkg::EXT_RAM_SIZE
    |=> route_valid && target == timing_pkg::TGT_EXT_RAM)
    else $error("low external address not routed on chip");
  route_off_a: assert property (
    accept && issue.op == timing_pkg::OP_EXT_MOVE && !issue.flash_access &&
    issue.ptr_wide && issue.ext_addr >= timing_pkg::EXT_RAM_SIZE
    |=> route_valid && target == timing_pkg::TGT_OFF_CHIP)
    else $error("high external address not routed off chip");
  route_flash_a: assert property (
    accept && issue.op == timing_pkg::OP_EXT_MOVE && issue.flash_access
    |=> target == timing_pkg::TGT_FLASH)
    else $error("flash access not routed to flash");
  nibble_mask_a: assert property (
    accept && issue.op == timing_pkg::OP_LOW_NIBBLE_XCH |=> nibble_mask == 8'h0f)
    else $error("low nibble exchange mask wrong");

  // Per-class timing checks on the latched byte and cycle counts
  add_reg_a: assert property (
    accept && issue.op == timing_pkg::OP_ADD &&
    issue.src == timing_pkg::MODE_REG
    |=> bytes_out == timing_pkg::LEN_1 && cycles_out == timing_pkg::CYC_1)
    else $error("register add not one byte one cycle");
  addc_direct_a: assert property (
    accept && issue.op == timing_pkg::OP_ADDC &&
    issue.src == timing_pkg::MODE_DIRECT
    |=> bytes_out == timing_pkg::LEN_2 && cycles_out == timing_pkg::CYC_2)
    else $error("direct add with carry not two bytes two cycles");
  subb_imm_a: assert property (
    accept && issue.op == timing_pkg::OP_SUBB &&
    issue.src == timing_pkg::MODE_IMM
    |=> bytes_out == timing_pkg::LEN_2 && cycles_out == timing_pkg::CYC_2)
    else $error("immediate subtract not two bytes two cycles");
  add_ind_a: assert property (
    accept && issue.op == timing_pkg::OP_ADD &&
    issue.src == timing_pkg::MODE_INDIRECT
    |=> bytes_out == timing_pkg::LEN_1 && cycles_out == timing_pkg::CYC_2)
    else $error("indirect add not one byte two cycles");
  dec_ind_a: assert property (
    accept && issue.op == timing_pkg::OP_DEC &&
    issue.dst == timing_pkg::MODE_INDIRECT
    |=> cycles_out == timing_pkg::CYC_2)
    else $error("indirect decrement not two cycles");
  inc_acc_a: assert property (
    accept && issue.op == timing_pkg::OP_INC &&
    issue.dst == timing_pkg::MODE_ACC
    |=> cycles_out == timing_pkg::CYC_1)
    else $error("accumulator increment not one cycle");
  ptr_inc_a: assert property (
    accept && issue.op == timing_pkg::OP_INC_DATA_POINTER_PAIR
    |=> bytes_out == timing_pkg::LEN_1 && cycles_out == timing_pkg::CYC_1)
    else $error("pointer pair increment not one byte one cycle");
  logic_direct_a: assert property (
    accept && issue.op == timing_pkg::OP_LOGIC &&
    issue.dst == timing_pkg::MODE_DIRECT && issue.src == timing_pkg::MODE_ACC
    |=> bytes_out == timing_pkg::LEN_2 && cycles_out == timing_pkg::CYC_2)
    else $error("logic into direct byte not two bytes two cycles");
  logic_ind_a: assert property (
    accept && issue.op == timing_pkg::OP_LOGIC &&
    issue.dst == timing_pkg::MODE_ACC && issue.src == timing_pkg::MODE_INDIRECT
    |=> cycles_out == timing_pkg::CYC_2)
    else $error("logic from indirect source not two cycles");
  acc_only_a: assert property (
    accept && issue.op == timing_pkg::OP_ACC_ONLY
    |=> bytes_out == timing_pkg::LEN_1 && cycles_out == timing_pkg::CYC_1)
    else $error("accumulator-only op not one cycle");
  mov_direct_a: assert property (
    accept && issue.op == timing_pkg::OP_MOV &&
    issue.dst == timing_pkg::MODE_DIRECT && issue.src == timing_pkg::MODE_DIRECT
    |=> bytes_out == timing_pkg::LEN_3 && cycles_out == timing_pkg::CYC_3)
    else $error("direct to direct move not three bytes three cycles");
  mov_reg_a: assert property (
    accept && issue.op == timing_pkg::OP_MOV &&
    issue.dst == timing_pkg::MODE_REG && issue.src == timing_pkg::MODE_IMM
    |=> bytes_out == timing_pkg::LEN_2 && cycles_out == timing_pkg::CYC_2)
    else $error("register load not two bytes two cycles");
  mov_ind_a: assert property (
    accept && issue.op == timing_pkg::OP_MOV &&
    issue.dst == timing_pkg::MODE_INDIRECT
    |=> cycles_out == timing_pkg::CYC_2)
    else $error("move into indirect RAM not two cycles");
  ptr_load_a: assert property (
    accept && issue.op == timing_pkg::OP_MOV_DATA_POINTER_PAIR
    |=> bytes_out == timing_pkg::LEN_3 && cycles_out == timing_pkg::CYC_3)
    else $error("pointer pair load not three bytes three cycles");
  code_read_a: assert property (
    accept && issue.op == timing_pkg::OP_CODE_READ
    |=> bytes_out == timing_pkg::LEN_1 && cycles_out == timing_pkg::CYC_3)
    else $error("code read not one byte three cycles");
  push_pop_a: assert property (
    accept && (issue.op == timing_pkg::OP_PUSH ||
    issue.op == timing_pkg::OP_POP)
    |=> bytes_out == timing_pkg::LEN_2 && cycles_out == timing_pkg::CYC_2)
    else $error("push or pop not two bytes two cycles");
  xch_reg_a: assert property (
    accept && issue.op == timing_pkg::OP_XCH &&
    issue.src == timing_pkg::MODE_REG
    |=> cycles_out == timing_pkg::CYC_1 && nibble_mask == timing_pkg::MASK_ALL)
    else $error("register exchange not one cycle full byte");
  bit_write_a: assert property (
    accept && issue.op == timing_pkg::OP_BIT_SET_CLR
    |=> bytes_out == timing_pkg::LEN_2 && cycles_out == timing_pkg::CYC_2)
    else $error("direct bit set or clear not two bytes two cycles");

  div_seen_c: cover property (accept && issue.op == timing_pkg::OP_DIV ##8 done);
  off_chip_c: cover property (route_valid && target == timing_pkg::TGT_OFF_CHIP);
  back_to_back_c: cover property (done && accept);
  narrow_ext_c: cover property (accept &&
    issue.op == timing_pkg::OP_EXT_MOVE && !issue.ptr_wide);
  branch_taken_c: cover property (accept &&
    issue.op == timing_pkg::OP_COND_BRANCH && issue.taken);
endmodule

// File: logic/timing_lookup.sv
// Byte length and cycle count lookup for one instruction
`timescale 1ns/1ps
module timing_lookup (
  // Instruction in
  input wire timing_pkg::instr_t instr,
  // Timing out
  output timing_pkg::timing_t timing
);
  function automatic timing_pkg::timing_t pick(input logic [1:0] b,
                                               input logic [3:0] c);
    timing_pkg::timing_t t;
    t.bytes = b;
    t.cycles = c;
    return t;
  endfunction

  // Shape shared by arithmetic, increment and exchange: reg or acc 1/1,
  // direct or immediate 2/2, indirect 1/2
  function automatic timing_pkg::timing_t by_src(input timing_pkg::mode_t m);
    timing_pkg::timing_t t;
    case (m)
      timing_pkg::MODE_ACC,
      timing_pkg::MODE_REG: t = pick(timing_pkg::LEN_1, timing_pkg::CYC_1);
      timing_pkg::MODE_INDIRECT:
        t = pick(timing_pkg::LEN_1, timing_pkg::CYC_2);
      default: t = pick(timing_pkg::LEN_2, timing_pkg::CYC_2);
    endcase
    return t;
  endfunction

  always_comb begin
    timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_1);
    case (instr.op)
      timing_pkg::OP_ADD, timing_pkg::OP_ADDC,
      timing_pkg::OP_SUBB: timing = by_src(instr.src);
      timing_pkg::OP_INC, timing_pkg::OP_DEC: timing = by_src(instr.dst);
      timing_pkg::OP_INC_DATA_POINTER_PAIR:
        timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_1);
      timing_pkg::OP_MUL:
        timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_4);
      timing_pkg::OP_DIV:
        timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_8);
      timing_pkg::OP_DECIMAL_ADJUST, timing_pkg::OP_ACC_ONLY,
      timing_pkg::OP_CARRY:
        timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_1);
      timing_pkg::OP_LOGIC: begin
        if (instr.dst == timing_pkg::MODE_DIRECT) begin
          if (instr.src == timing_pkg::MODE_IMM)
            timing = pick(timing_pkg::LEN_3, timing_pkg::CYC_3);
          else
            timing = pick(timing_pkg::LEN_2, timing_pkg::CYC_2);
        end else begin
          timing = by_src(instr.src);
        end
      end
      timing_pkg::OP_MOV: begin
        case (instr.dst)
          timing_pkg::MODE_DIRECT: begin
            if (instr.src == timing_pkg::MODE_DIRECT ||
                instr.src == timing_pkg::MODE_IMM)
              timing = pick(timing_pkg::LEN_3, timing_pkg::CYC_3);
            else
              timing = pick(timing_pkg::LEN_2, timing_pkg::CYC_2);
          end
          timing_pkg::MODE_INDIRECT: begin
            if (instr.src == timing_pkg::MODE_ACC)
              timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_2);
            else
              timing = pick(timing_pkg::LEN_2, timing_pkg::CYC_2);
          end
          default: timing = by_src(instr.src);
        endcase
      end
      timing_pkg::OP_MOV_DATA_POINTER_PAIR:
        timing = pick(timing_pkg::LEN_3, timing_pkg::CYC_3);
      timing_pkg::OP_CODE_READ, timing_pkg::OP_EXT_MOVE:
        timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_3);
      timing_pkg::OP_PUSH, timing_pkg::OP_POP, timing_pkg::OP_BIT_SET_CLR:
        timing = pick(timing_pkg::LEN_2, timing_pkg::CYC_2);
      timing_pkg::OP_XCH: timing = by_src(instr.src);
      timing_pkg::OP_LOW_NIBBLE_XCH:
        timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_2);
      timing_pkg::OP_COND_BRANCH:
        // One cycle per byte, plus one more when the branch is taken
        timing = pick(instr.branch_len,
                      {2'h0, instr.branch_len} + {3'h0, instr.taken});
      default: timing = pick(timing_pkg::LEN_1, timing_pkg::CYC_1);
    endcase
  end
endmodule

// File: logic/timing_pkg.sv
// Shared types and constants for the instruction timing block
package timing_pkg;
  // Byte and cycle counts
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_8 = 4'h8;
  // On-chip external data RAM occupies the low part of the 16-bit space
  localparam logic [15:0] EXT_RAM_SIZE = 16'h2000;
  // Nibble masks for the exchange unit
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_LOW = 8'h0f;
  localparam logic [7:0] MASK_ALL = 8'hff;

  typedef enum logic [4:0] {
    OP_ADD = 5'b00000,
    OP_ADDC = 5'b00001,
    OP_SUBB = 5'b00010,
    OP_INC = 5'b00011,
    OP_DEC = 5'b00100,
    OP_INC_DATA_POINTER_PAIR = 5'b00101,
    OP_MUL = 5'b00110,
    OP_DIV = 5'b00111,
    OP_DECIMAL_ADJUST = 5'b01000,
    OP_LOGIC = 5'b01001,
    OP_ACC_ONLY = 5'b01010,
    OP_MOV = 5'b01011,
    OP_MOV_DATA_POINTER_PAIR = 5'b01100,
    OP_CODE_READ = 5'b01101,
    OP_EXT_MOVE = 5'b01110,
    OP_PUSH = 5'b01111,
    OP_POP = 5'b10000,
    OP_XCH = 5'b10001,
    OP_LOW_NIBBLE_XCH = 5'b10010,
    OP_CARRY = 5'b10011,
    OP_BIT_SET_CLR = 5'b10100,
    OP_COND_BRANCH = 5'b10101
  } op_t;

  typedef enum logic [2:0] {
    MODE_ACC = 3'b000,
    MODE_REG = 3'b001,
    MODE_DIRECT = 3'b010,
    MODE_INDIRECT = 3'b011,
    MODE_IMM = 3'b100
  } mode_t;

  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_EXT_RAM = 2'b01,
    TGT_OFF_CHIP = 2'b10,
    TGT_FLASH = 2'b11
  } target_t;

  typedef struct packed {
    op_t op;
    mode_t dst;
    mode_t src;
    logic taken;
    logic [1:0] branch_len;
    logic ptr_wide;
    logic [15:0] ext_addr;
    logic flash_access;
  } instr_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
  } timing_t;
endpackage

// File: sim/byte_cpu_instruction_timing_tb.sv
// Self-checking bench for the instruction timing sequencer
`timescale 1ns/1ps
module byte_cpu_instruction_timing_tb;
  localparam timing_pkg::mode_t ACC = timing_pkg::MODE_ACC;
  localparam timing_pkg::mode_t REG = timing_pkg::MODE_REG;
  localparam timing_pkg::mode_t DIR = timing_pkg::MODE_DIRECT;
  localparam timing_pkg::mode_t IND = timing_pkg::MODE_INDIRECT;
  localparam timing_pkg::mode_t IMM = timing_pkg::MODE_IMM;
  logic ref_clk;
  logic sys_rst;
  logic issue_valid;
  timing_pkg::instr_t issue;
  logic ready;
  logic done;
  logic [1:0] bytes_out;
  logic [3:0] cycles_out;
  logic [7:0] nibble_mask;
  logic route_valid;
  timing_pkg::target_t target;
  logic [15:0] route_addr;
  logic route_wide;
  logic [7:0] ram_hits;
  logic [7:0] off_hits;
  logic [7:0] flash_hits;
  logic [7:0] bad_hits;
  logic [19:0] rt_seen;
  int failures;
  int compares;

  instr_timing instr_timing_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .issue_valid(issue_valid),
    .issue(issue),
    .ready(ready),
    .done(done),
    .bytes_out(bytes_out),
    .cycles_out(cycles_out),
    .nibble_mask(nibble_mask),
    .route_valid(route_valid),
    .target(target),
    .route_addr(route_addr),
    .route_wide(route_wide)
  );

  ext_target_model ext_target_model_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .route_valid(route_valid),
    .target(target),
    .route_addr(route_addr),
    .ram_hits(ram_hits),
    .off_hits(off_hits),
    .flash_hits(flash_hits),
    .bad_hits(bad_hits)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task stop_test;
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic timing_pkg::instr_t mk(input timing_pkg::op_t o,
                                            input timing_pkg::mode_t d,
                                            input timing_pkg::mode_t s);
    mk = '0;
    mk.op = o;
    mk.dst = d;
    mk.src = s;
  endfunction

  // Issues one instruction, checks its timing fields and done spacing
  task automatic op(input timing_pkg::instr_t i, input logic [1:0] eb,
                    input logic [3:0] ec);
    int k;
    logic [7:0] em;
    em = 8'h00;
    if (i.op == timing_pkg::OP_XCH) em = 8'hff;
    if (i.op == timing_pkg::OP_LOW_NIBBLE_XCH) em = 8'h0f;
    @(posedge ref_clk);
    issue_valid <= 1'b1;
    issue <= i;
    @(posedge ref_clk);
    issue_valid <= 1'b0;
    #1;
    rt_seen = {route_valid, route_wide, target, route_addr};
    chk(32'({bytes_out, cycles_out, nibble_mask}), 32'({eb, ec, em}));
    if (i.op != timing_pkg::OP_EXT_MOVE) chk(32'(rt_seen[19:16]), 32'h0);
    k = 1;
    while (done !== 1'b1 && k < 12) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 12) begin
      failures++;
      stop_test();
    end
    chk(32'(k), 32'(ec));
  endtask

  task arith_timing;
    op(mk(timing_pkg::OP_ADD, ACC, REG), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_SUBB, ACC, REG), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_ADDC, ACC, DIR), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_SUBB, ACC, IMM), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_ADD, ACC, IND), 2'h1, 4'h2);
    op(mk(timing_pkg::OP_INC, ACC, ACC), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_DEC, IND, IND), 2'h1, 4'h2);
    op(mk(timing_pkg::OP_INC, DIR, DIR), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_INC_DATA_POINTER_PAIR, ACC, ACC), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_MUL, ACC, ACC), 2'h1, 4'h4);
    op(mk(timing_pkg::OP_DECIMAL_ADJUST, ACC, ACC), 2'h1, 4'h1);
  endtask

  task logic_timing;
    op(mk(timing_pkg::OP_LOGIC, DIR, IMM), 2'h3, 4'h3);
    op(mk(timing_pkg::OP_LOGIC, DIR, ACC), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_LOGIC, ACC, IMM), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_LOGIC, ACC, REG), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_LOGIC, ACC, IND), 2'h1, 4'h2);
    op(mk(timing_pkg::OP_ACC_ONLY, ACC, ACC), 2'h1, 4'h1);
  endtask

  task move_timing;
    op(mk(timing_pkg::OP_MOV, DIR, DIR), 2'h3, 4'h3);
    op(mk(timing_pkg::OP_MOV, DIR, IMM), 2'h3, 4'h3);
    op(mk(timing_pkg::OP_MOV, REG, IMM), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_MOV, ACC, REG), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_MOV, IND, ACC), 2'h1, 4'h2);
    op(mk(timing_pkg::OP_MOV, IND, IMM), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_MOV_DATA_POINTER_PAIR, ACC, IMM), 2'h3, 4'h3);
    op(mk(timing_pkg::OP_CODE_READ, ACC, ACC), 2'h1, 4'h3);
    op(mk(timing_pkg::OP_PUSH, DIR, DIR), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_POP, DIR, DIR), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_XCH, ACC, REG), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_XCH, ACC, DIR), 2'h2, 4'h2);
    op(mk(timing_pkg::OP_LOW_NIBBLE_XCH, ACC, IND), 2'h1, 4'h2);
    op(mk(timing_pkg::OP_CARRY, ACC, ACC), 2'h1, 4'h1);
    op(mk(timing_pkg::OP_BIT_SET_CLR, DIR, DIR), 2'h2, 4'h2);
  endtask

  task branch_timing;
    timing_pkg::instr_t i;
    i = mk(timing_pkg::OP_COND_BRANCH, ACC, ACC);
    for (int t = 0; t < 2; t++) begin
      for (int n = 2; n < 4; n++) begin
        i.taken = t[0];
        i.branch_len = n[1:0];
        op(i, n[1:0], 4'(n + t));
      end
    end
  endtask

  task automatic ext1(input logic [15:0] a, input logic w, input logic f,
                      input timing_pkg::target_t t, input logic [15:0] ea);
    timing_pkg::instr_t i;
    i = mk(timing_pkg::OP_EXT_MOVE, ACC, ACC);
    i.ext_addr = a;
    i.ptr_wide = w;
    i.flash_access = f;
    op(i, 2'h1, 4'h3);
    chk(32'(rt_seen), 32'({1'b1, w, t, ea}));
  endtask

  task ext_route;
    ext1(16'h1fff, 1'b1, 1'b0, timing_pkg::TGT_EXT_RAM, 16'h1fff);
    ext1(16'h2000, 1'b1, 1'b0, timing_pkg::TGT_OFF_CHIP, 16'h2000);
    ext1(16'hffff, 1'b1, 1'b0, timing_pkg::TGT_OFF_CHIP, 16'hffff);
    ext1(16'hab34, 1'b0, 1'b1, timing_pkg::TGT_FLASH, 16'h0034);
    ext1(16'h4055, 1'b0, 1'b0, timing_pkg::TGT_EXT_RAM, 16'h0055);
    chk({ram_hits, off_hits, flash_hits, bad_hits}, 32'h02020100);
  endtask

  // A request held high while busy must wait for the divide to finish
  task refuse_while_busy;
    @(posedge ref_clk);
    issue_valid <= 1'b1;
    issue <= mk(timing_pkg::OP_DIV, ACC, ACC);
    @(posedge ref_clk);
    issue <= mk(timing_pkg::OP_CARRY, ACC, ACC);
    for (int k = 1; k < 8; k++) begin
      #1;
      chk(32'({ready, done, cycles_out}), 32'h08);
      @(posedge ref_clk);
    end
    #1;
    chk(32'({ready, done, cycles_out}), 32'h38);
    @(posedge ref_clk);
    issue_valid <= 1'b0;
    #1;
    chk(32'({done, cycles_out}), 32'h11);
  endtask

  initial begin
    #2000000;
    failures++;
    stop_test();
  end

  initial begin
    failures = 0;
    compares = 0;
    sys_rst = 1'b1;
    issue_valid = 1'b0;
    issue = '0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk(32'({ready, done, bytes_out, cycles_out, nibble_mask}), 32'h8000);
    chk(32'({route_valid, route_wide, target, route_addr}), 32'h0);
    arith_timing();
    logic_timing();
    move_timing();
    branch_timing();
    ext_route();
    refuse_while_busy();
    stop_test();
  end
endmodule

// File: sim/ext_target_model.sv
// Far-side model of on-chip data RAM, off-chip memory and flash
`timescale 1ns/1ps
module ext_target_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Routed access
  input wire logic route_valid,
  input wire timing_pkg::target_t target,
  input wire logic [15:0] route_addr,
  // Hit counts
  output logic [7:0] ram_hits,
  output logic [7:0] off_hits,
  output logic [7:0] flash_hits,
  output logic [7:0] bad_hits
);
  // Each region counts every access routed to it; RAM or off-chip accesses outside their address range also count as bad
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ram_hits <= 8'h00;
      off_hits <= 8'h00;
      flash_hits <= 8'h00;
      bad_hits <= 8'h00;
    end else if (route_valid) begin
      case (target)
        timing_pkg::TGT_EXT_RAM: begin
          ram_hits <= ram_hits + 8'h01;
          if (route_addr >= timing_pkg::EXT_RAM_SIZE) begin
            bad_hits <= bad_hits + 8'h01;
          end
        end
        timing_pkg::TGT_OFF_CHIP: begin
          off_hits <= off_hits + 8'h01;
          if (route_addr < timing_pkg::EXT_RAM_SIZE) begin
            bad_hits <= bad_hits + 8'h01;
          end
        end
        timing_pkg::TGT_FLASH: begin
          flash_hits <= flash_hits + 8'h01;
        end
        default: begin
          bad_hits <= bad_hits + 8'h01;
        end
      endcase
    end
  end
endmodule
